/* testbench.sv */
// self-checking bench of urib_core beside the FIFO stand-in
// assumes one 40 MHz mclk and the offsets of urib_defines.svh
`timescale 1ns/10ps
`include "urib_defines.svh"
module testbench;
	// ----------------------------------------
	// signals and rows
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] fifo;
		logic [7:0] feat;
		logic [6:0] tx;
		logic [6:0] rx;
		logic       idle;
		logic [2:0] pins;
	} urib_row_t;
	logic       mclk      = 1'b0;
	logic       reset_n   = 1'b0;
	logic [3:0] regAddr   = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic       regWrite  = 1'b0;
	logic       regRead   = 1'b0;
	logic [6:0] txGoal    = 7'h00;
	logic [6:0] rxGoal    = 7'h00;
	logic       shiftIdle = 1'b1;
	logic       strapPin  = 1'b0;
	logic [2:0] pinWord;
	logic [7:0] regRdData;
	logic [6:0] txCount, rxCount;
	logic       tsrEmpty, rxArrive, rxTake, rxReadyN, txReadyN;
	logic       irqOut, rxTimeout, sampleTick, bitTick;
	int         n_fail = 0;
	int         comparisons = 0;
	// pins are {rxReadyN, txReadyN, irqOut}
	urib_row_t  rows [12] = '{
		{8'h00, 8'h00, 7'h00, 7'h00, 1'b1, 3'h5},
		{8'h00, 8'h00, 7'h01, 7'h01, 1'b1, 3'h3},
		{8'h00, 8'h00, 7'h01, 7'h00, 1'b1, 3'h6},
		{8'h00, 8'h08, 7'h00, 7'h00, 1'b0, 3'h4},
		{8'h00, 8'h08, 7'h00, 7'h00, 1'b1, 3'h5},
		{8'h01, 8'h00, 7'h08, 7'h07, 1'b1, 3'h2},
		{8'h01, 8'h00, 7'h07, 7'h00, 1'b1, 3'h7},
		{8'h01, 8'h00, 7'h08, 7'h08, 1'b1, 3'h3},
		{8'h01, 8'h08, 7'h00, 7'h00, 1'b0, 3'h5},
		{8'h09, 8'h00, 7'h3F, 7'h00, 1'b1, 3'h4},
		{8'h09, 8'h00, 7'h40, 7'h00, 1'b1, 3'h6},
		{8'h09, 8'h00, 7'h00, 7'h08, 1'b1, 3'h1}};

	// ----------------------------------------
	// design, stand-in, clock
	// ----------------------------------------
	// clock enable stays high; the strap is driven by the last reset test
	urib_core #(.FIFO_DEPTH(64)) uut (
		.mclk(mclk), .reset_n(reset_n), .ce(1'b1), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .txCount(txCount), .rxCount(rxCount),
		.tsrEmpty(tsrEmpty), .rxArrive(rxArrive), .rxTake(rxTake),
		.prescaleSelectPin(strapPin), .rxReadyN(rxReadyN),
		.txReadyN(txReadyN), .irqOut(irqOut), .rxTimeout(rxTimeout),
		.sampleTick(sampleTick), .bitTick(bitTick));
	urib_fifo_model #(.FIFO_DEPTH(64)) far (
		.mclk(mclk), .reset_n(reset_n), .txGoal(txGoal),
		.rxGoal(rxGoal), .shiftIdle(shiftIdle), .txCount(txCount),
		.rxCount(rxCount), .tsrEmpty(tsrEmpty), .rxArrive(rxArrive),
		.rxTake(rxTake));
	// pins packed as the rows hold them
	assign pinWord = {rxReadyN, txReadyN, irqOut};
	// 25 ns period
	initial
	begin
		forever #12.5 mclk = ~mclk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// every driver starts on a rising edge and drives by nba
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		@(negedge mclk);
		d = regRdData;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic goal(input logic [6:0] t, input logic [6:0] r,
	                    input int n);
		@(posedge mclk);
		txGoal <= t;
		rxGoal <= r;
		settle(n);
	endtask
	// skips one tick so a divisor change never shows a short gap
	task automatic gap(input logic useBit, output int n);
		repeat (2)
		begin
			n = 0;
			do
			begin
				@(negedge mclk);
				n++;
			end
			while (n < 4000 && (useBit ? bitTick : sampleTick) !== 1'b1);
		end
	endtask
	// negedges from the call until the time-out level shows
	task automatic wait_timeout(output int n);
		n = 0;
		while (rxTimeout !== 1'b1 && n < 1000)
		begin
			@(negedge mclk);
			n++;
		end
	endtask
	task automatic cmp(input string what, input logic [15:0] exp,
	                   input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	// watchdog well beyond the few thousand cycles the tests need
	initial
	begin
		#(25 * 20000);
		n_fail++;
		close_out();
	end

	// rows first, then reset, status, block, time-out and rate cases
	initial
	begin
		logic [7:0] d;
		int n;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		foreach (rows[i])
		begin
			wr(`URIB_ADDR_FIFO_CTL, rows[i].fifo);
			wr(`URIB_ADDR_FEAT_CTL, rows[i].feat);
			@(posedge mclk);
			shiftIdle <= rows[i].idle;
			goal(rows[i].tx, rows[i].rx, 70);
			cmp("pins", 16'(rows[i].pins),
			    16'(pinWord));
			$display("row %0d done", i);
		end
		goal(7'h00, 7'h00, 0);
		@(posedge mclk);
		shiftIdle <= 1'b1;
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		rd(`URIB_ADDR_DIV_LOW, d);
		cmp("divLow", 16'h0001, 16'(d));
		rd(`URIB_ADDR_DIV_HIGH, d);
		cmp("divHigh", 16'h0000, 16'(d));
		rd(`URIB_ADDR_ENH_MODE, d);
		cmp("enhMode", 16'h0080, 16'(d));
		rd(4'hA, d);
		cmp("unmapped", 16'h0000, 16'(d));
		$display("reset test done");
		wr(`URIB_ADDR_LINE_STAT, 8'h00);
		rd(`URIB_ADDR_LINE_STAT, d);
		cmp("lineStat", 16'h0060, 16'(d));
		goal(7'h05, 7'h01, 8);
		rd(`URIB_ADDR_LINE_STAT, d);
		cmp("lineStat", 16'h0001, 16'(d));
		$display("status test done");
		wr(`URIB_ADDR_FIFO_CTL, 8'h09);
		goal(7'h05, 7'h08, 12);
		goal(7'h05, 7'h03, 12);
		cmp("rxReadyN", 16'h0000, 16'(rxReadyN));
		goal(7'h05, 7'h00, 8);
		cmp("rxReadyN", 16'h0001, 16'(rxReadyN));
		goal(7'h05, 7'h02, 0);
		wait_timeout(n);
		cmp("timeoutWindow", 16'h0001, 16'(n >= 495 && n <= 520));
		settle(2);
		cmp("rxReadyN", 16'h0000, 16'(rxReadyN));
		// eight-bit words: 44 bit times of silence
		wr(`URIB_ADDR_LINE_CTL, 8'h03);
		goal(7'h05, 7'h00, 4);
		goal(7'h05, 7'h02, 0);
		wait_timeout(n);
		cmp("timeoutWindow", 16'h0001, 16'(n >= 688 && n <= 712));
		$display("block test done");
		gap(1'b1, n);
		cmp("bitGap", 16'h0010, 16'(n));
		wr(`URIB_ADDR_DIV_LOW, 8'h03);
		gap(1'b0, n);
		cmp("sampleGap", 16'h0003, 16'(n));
		wr(`URIB_ADDR_ENH_MODE, 8'h00);
		gap(1'b1, n);
		cmp("bitGap", 16'h0018, 16'(n));
		wr(`URIB_ADDR_MODEM_CTL, 8'h80);
		gap(1'b0, n);
		cmp("sampleGap", 16'h000C, 16'(n));
		rd(`URIB_ADDR_MODEM_CTL, d);
		cmp("modemCtl", 16'h0080, 16'(d));
		wr(`URIB_ADDR_DIV_HIGH, 8'h01);
		wr(`URIB_ADDR_DIV_LOW, 8'h00);
		gap(1'b0, n);
		cmp("sampleGap", 16'h0400, 16'(n));
		$display("rate test done");
		// strap high through a reset, then software takes the prescaler
		@(posedge mclk);
		strapPin <= 1'b1;
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		settle(8);
		gap(1'b0, n);
		cmp("sampleGap", 16'h0004, 16'(n));
		rd(`URIB_ADDR_MODEM_CTL, d);
		cmp("modemCtl", 16'h0080, 16'(d));
		wr(`URIB_ADDR_MODEM_CTL, 8'h00);
		gap(1'b0, n);
		cmp("sampleGap", 16'h0001, 16'(n));
		$display("strap test done");
		close_out();
	end
endmodule

/* urib_core.sv */
// ready pins, interrupt pin, rate generator and control registers
// of one channel; assumes FIFO counts come from logic on mclk
//
// What this block does
// - block bit clear means single-character mode; it affects ready pins only
// - receive-ready low while receive data present, high when none remains
// - block: receive-ready falls at trigger or time-out, rises when empty
// - FIFO single mode: transmit-ready low only while transmit FIFO empty
// - block mode: transmit-ready low with any free slot, high only when full
// - no FIFO: transmit interrupt low while byte waits; high when emptied, with auto direction only when whole transmitter empty
// - FIFO, no auto direction: transmit irq high below trigger or with count zero, else low
// - FIFO with auto direction: high below trigger or whole transmitter empty
// - receive interrupt high with one byte or FIFO at or above trigger
// - register access never waits on the baud clock
// - prescaler divides by 1 or 4, pin choice, modem bit 7 overrides
// - sixteen-bit divisor from 1 to 65535 gives the sampling clock
// - divisor low resets to one, high to zero
// - enhanced-mode bit 7 picks 16 or 8 samples per bit
// - line status bits 5 and 6 show transmit count zero and transmitter empty
// - transmit and receive FIFOs hold 64 bytes each
// - time-out after four words plus twelve bit times without new data or a host read
`timescale 1ns/10ps
`include "urib_defines.svh"
module urib_core
	import urib_pkg::*;
#(
	parameter int FIFO_DEPTH = 64
)
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        ce,
	// register port
	input wire logic [3:0]  regAddr,
	input wire logic [7:0]  regWrData,
	input wire logic        regWrite,
	input wire logic        regRead,
	output logic [7:0]      regRdData,
	// FIFO and shifter status
	input wire logic [6:0]  txCount,
	input wire logic [6:0]  rxCount,
	input wire logic        tsrEmpty,
	input wire logic        rxArrive,
	input wire logic        rxTake,
	// strap pin
	input wire logic        prescaleSelectPin,
	// pins and ticks out
	output logic            rxReadyN,
	output logic            txReadyN,
	output logic            irqOut,
	output logic            rxTimeout,
	output logic            sampleTick,
	output logic            bitTick
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// counts are seven bits wide, so the depth must fit below 128
	if (FIFO_DEPTH < 1 || FIFO_DEPTH > 127)
	begin : gDepthCheck
		$error("FIFO_DEPTH must lie between 1 and 127");
	end

	localparam logic [6:0] DEPTH = 7'(FIFO_DEPTH);

	// ----------------------------------------------------------------
	// state and wiring
	// ----------------------------------------------------------------
	urib_core_t  s;
	urib_core_t  next_s;
	urib_tick_if ticks ();
	logic        timeoutLevel;
	logic        fifoOn;
	logic        blockMode;
	logic        autoDir;
	logic        prescale4;
	logic        txAllEmpty;
	logic        txIrq;
	logic        rxIrq;
	logic [7:0]  lineStatus;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// a write strobe aimed at one offset
	function automatic logic hitWrite(input logic wr,
	                                  input logic [3:0] addr,
	                                  input logic [3:0] target);
		hitWrite = wr && (addr == target);
	endfunction

	// count at or above a trigger held in an eight-bit register
	function automatic logic atTrigger(input logic [6:0] count,
	                                   input logic [7:0] trig);
		atTrigger = ({1'b0, count} >= trig);
	endfunction

	// ----------------------------------------------------------------
	// decoded settings
	// ----------------------------------------------------------------
	// mode bits decoded once for the pin logic
	always_comb
	begin
		fifoOn = s.fifoCtl[`URIB_FCR_FIFO_EN];
		blockMode = fifoOn && s.fifoCtl[`URIB_FCR_BLOCK];
		autoDir = s.featCtl[`URIB_FTR_AUTO_DIR];
		// software wins once it has written the modem control register
		prescale4 = s.prescaleOwned ? s.modemCtl[`URIB_MCR_PRESCALE]
		                            : s.prescalePin;
		txAllEmpty = (txCount == 7'h00) && tsrEmpty;
	end

	// ----------------------------------------------------------------
	// rate generator and time-out
	// ----------------------------------------------------------------
	// settings read straight from mclk registers, never from the ticks
	assign ticks.divisor = {s.divHigh, s.divLow};
	assign ticks.prescale4 = prescale4;
	assign ticks.mode16 = s.enhMode[`URIB_EMR_MODE16];

	urib_rate_divider uRate (
		.mclk    (mclk),
		.reset_n (reset_n),
		.ce      (ce),
		.ticks   (ticks)
	);

	urib_rx_timeout uTimeout (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.ce        (ce),
		.ticks     (ticks),
		.wordLen   (s.lineCtl[1:0]),
		.rxHasData (rxCount != 7'h00),
		.rxArrive  (rxArrive),
		.rxTake    (rxTake),
		.timeout   (timeoutLevel)
	);

	// ----------------------------------------------------------------
	// interrupt conditions
	// ----------------------------------------------------------------
	// transmitter and receiver sources share one active-high pin
	always_comb
	begin
		if (!fifoOn)
		begin
			// holding register only: any count means a byte waits
			if (autoDir)
				txIrq = txAllEmpty;
			else
				txIrq = (txCount == 7'h00);
			rxIrq = (rxCount != 7'h00);
		end
		else
		begin
			// a zero trigger still signals through the empty term
			if (autoDir)
				txIrq = !atTrigger(txCount, s.txTrig)
				        || txAllEmpty;
			else
				txIrq = !atTrigger(txCount, s.txTrig)
				        || (txCount == 7'h00);
			rxIrq = atTrigger(rxCount, s.rxTrig);
		end
	end

	// ----------------------------------------------------------------
	// line status
	// ----------------------------------------------------------------
	// only the status bits this block owns; the rest read as zero
	always_comb
	begin
		lineStatus = 8'h00;
		lineStatus[`URIB_LSR_RX_DATA] = (rxCount != 7'h00);
		lineStatus[`URIB_LSR_THR_EMPTY] = (txCount == 7'h00);
		lineStatus[`URIB_LSR_TX_EMPTY] = txAllEmpty;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;

		// strap pin: three stages, a change counts when the last two agree
		next_s.pinSync = {s.pinSync[1:0], prescaleSelectPin};
		if (s.pinSync[1] == s.pinSync[2])
			next_s.prescalePin = s.pinSync[2];

		// register writes, single cycle, never stalled
		if (hitWrite(regWrite, regAddr, `URIB_ADDR_DIV_LOW))
			next_s.divLow = regWrData;
		if (hitWrite(regWrite, regAddr, `URIB_ADDR_DIV_HIGH))
			next_s.divHigh = regWrData;
		if (hitWrite(regWrite, regAddr, `URIB_ADDR_FIFO_CTL))
			next_s.fifoCtl = regWrData;
		if (hitWrite(regWrite, regAddr, `URIB_ADDR_LINE_CTL))
			next_s.lineCtl = regWrData;
		if (hitWrite(regWrite, regAddr, `URIB_ADDR_MODEM_CTL))
		begin
			next_s.modemCtl = regWrData;
			next_s.prescaleOwned = 1'b1;
		end
		if (hitWrite(regWrite, regAddr, `URIB_ADDR_ENH_MODE))
			next_s.enhMode = regWrData;
		if (hitWrite(regWrite, regAddr, `URIB_ADDR_FEAT_CTL))
			next_s.featCtl = regWrData;
		if (hitWrite(regWrite, regAddr, `URIB_ADDR_TX_TRIG))
			next_s.txTrig = regWrData;
		if (hitWrite(regWrite, regAddr, `URIB_ADDR_RX_TRIG))
			next_s.rxTrig = regWrData;

		// read data live for one cycle after the strobe, else zero
		next_s.rdData = 8'h00;
		if (regRead)
		begin
			unique case (regAddr)
				`URIB_ADDR_DIV_LOW:   next_s.rdData = s.divLow;
				`URIB_ADDR_DIV_HIGH:  next_s.rdData = s.divHigh;
				`URIB_ADDR_FIFO_CTL:  next_s.rdData = s.fifoCtl;
				`URIB_ADDR_LINE_CTL:  next_s.rdData = s.lineCtl;
				`URIB_ADDR_MODEM_CTL: next_s.rdData = {prescale4,
				                                       s.modemCtl[6:0]};
				`URIB_ADDR_LINE_STAT: next_s.rdData = lineStatus;
				`URIB_ADDR_ENH_MODE:  next_s.rdData = s.enhMode;
				`URIB_ADDR_FEAT_CTL:  next_s.rdData = s.featCtl;
				`URIB_ADDR_TX_TRIG:   next_s.rdData = s.txTrig;
				`URIB_ADDR_RX_TRIG:   next_s.rdData = s.rxTrig;
				default:              next_s.rdData = 8'h00;
			endcase
		end

		// receive-ready pin
		if (!blockMode)
			next_s.rxReadyN = (rxCount == 7'h00);
		else if (rxCount == 7'h00)
			next_s.rxReadyN = 1'b1;
		else if (atTrigger(rxCount, s.rxTrig) || timeoutLevel)
			next_s.rxReadyN = 1'b0;

		// transmit-ready pin; without FIFOs it follows the holding byte
		if (blockMode)
			next_s.txReadyN = (txCount >= DEPTH);
		else
			next_s.txReadyN = (txCount != 7'h00);

		// interrupt pin
		next_s.irqOut = txIrq || rxIrq;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// asynchronous reset loads constants only; the strap settles later
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s <= '0;
			s.divLow <= `URIB_RST_DIV_LOW;
			s.divHigh <= `URIB_RST_DIV_HIGH;
			s.fifoCtl <= `URIB_RST_CTL;
			s.lineCtl <= `URIB_RST_CTL;
			s.modemCtl <= `URIB_RST_CTL;
			s.enhMode <= `URIB_RST_ENH_MODE;
			s.featCtl <= `URIB_RST_CTL;
			s.txTrig <= `URIB_RST_TRIG;
			s.rxTrig <= `URIB_RST_TRIG;
			s.rxReadyN <= 1'b1;
			s.txReadyN <= 1'b0;
			s.irqOut <= 1'b0;
		end
		else if (ce)
			s <= next_s;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign regRdData = s.rdData;
	assign rxReadyN = s.rxReadyN;
	assign txReadyN = s.txReadyN;
	assign irqOut = s.irqOut;
	assign rxTimeout = timeoutLevel;
	assign sampleTick = ticks.sampleTick;
	assign bitTick = ticks.bitTick;
endmodule

/* urib_core_properties.sv */
// timing checks on the pins of urib_core
// assumes it is bound into urib_core and sees only its ports
`timescale 1ns/10ps
module urib_core_checker
	import urib_pkg::*;
#(
	parameter int FIFO_DEPTH = 64
)
(
	// clock and reset
	input wire logic       mclk,
	input wire logic       reset_n,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic       regRead,
	input wire logic [7:0] regRdData,
	// status in
	input wire logic [6:0] txCount,
	input wire logic [6:0] rxCount,
	input wire logic       tsrEmpty,
	input wire logic       rxArrive,
	// pins out
	input wire logic       rxReadyN,
	input wire logic       txReadyN,
	input wire logic       irqOut,
	input wire logic       rxTimeout,
	input wire logic       sampleTick,
	input wire logic       bitTick
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	rd_idle_zero_a: assert property (!regRead |=> regRdData == 8'h00)
		else $error("read data not zero after idle cycle");
	rd_unmapped_a: assert property (regRead && regAddr > 4'h9 |=>
		regRdData == 8'h00) else $error("unmapped read not zero");
	rx_empty_high_a: assert property (rxCount == 7'h00 |=> rxReadyN)
		else $error("receive ready low with empty FIFO");
	tx_empty_low_a: assert property (txCount == 7'h00 |=> !txReadyN)
		else $error("transmit ready high with empty FIFO");
	tx_full_high_a: assert property (txCount == 7'(FIFO_DEPTH) |=>
		txReadyN) else $error("transmit ready low with full FIFO");
	tx_done_irq_a: assert property (txCount == 7'h00 && tsrEmpty |=>
		irqOut) else $error("no interrupt with empty transmitter");
	bit_on_sample_a: assert property (bitTick |-> sampleTick)
		else $error("bit tick without sample tick");
	to_clear_a: assert property (rxCount == 7'h00 || rxArrive |=>
		!rxTimeout) else $error("time-out not cleared");
	to_on_bit_a: assert property ($rose(rxTimeout) |-> $past(bitTick))
		else $error("time-out rose away from a bit tick");
endmodule

bind urib_core urib_core_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
	.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
	.regRead(regRead), .regRdData(regRdData), .txCount(txCount),
	.rxCount(rxCount), .tsrEmpty(tsrEmpty), .rxArrive(rxArrive),
	.rxReadyN(rxReadyN), .txReadyN(txReadyN), .irqOut(irqOut),
	.rxTimeout(rxTimeout), .sampleTick(sampleTick), .bitTick(bitTick));

/* urib_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes it is included by bare name from files that use the macros
`ifndef URIB_DEFINES_SVH
`define URIB_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define URIB_ADDR_DIV_LOW   4'h0
`define URIB_ADDR_DIV_HIGH  4'h1
`define URIB_ADDR_FIFO_CTL  4'h2
`define URIB_ADDR_LINE_CTL  4'h3
`define URIB_ADDR_MODEM_CTL 4'h4
`define URIB_ADDR_LINE_STAT 4'h5
`define URIB_ADDR_ENH_MODE  4'h6
`define URIB_ADDR_FEAT_CTL  4'h7
`define URIB_ADDR_TX_TRIG   4'h8
`define URIB_ADDR_RX_TRIG   4'h9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define URIB_FCR_FIFO_EN    0
`define URIB_FCR_BLOCK      3
`define URIB_MCR_PRESCALE   7
`define URIB_EMR_MODE16     7
`define URIB_FTR_AUTO_DIR   3
`define URIB_LSR_RX_DATA    0
`define URIB_LSR_THR_EMPTY  5
`define URIB_LSR_TX_EMPTY   6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define URIB_RST_DIV_LOW    8'h01
`define URIB_RST_DIV_HIGH   8'h00
`define URIB_RST_CTL        8'h00
`define URIB_RST_ENH_MODE   8'h80
`define URIB_RST_TRIG       8'h08

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define URIB_PRESCALE_LAST  2'h3
`define URIB_LAST_SAMPLE16  4'hF
`define URIB_LAST_SAMPLE8   4'h7
`define URIB_TO_CHARS       8'h04
`define URIB_TO_EXTRA_BITS  8'h0C
`define URIB_WORD_BASE      8'h05

`endif

/* urib_fifo_model.sv */
// stand-in for the host and the serial line: moves FIFO fill counts
// assumes goals come from the bench on mclk; one byte moves per cycle
`timescale 1ns/10ps
module urib_fifo_model
#(
	parameter int FIFO_DEPTH = 64
)
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// goals from the bench
	input wire logic [6:0]  txGoal,
	input wire logic [6:0]  rxGoal,
	input wire logic        shiftIdle,
	// status to the core
	output logic [6:0]      txCount,
	output logic [6:0]      rxCount,
	output logic            tsrEmpty,
	output logic            rxArrive,
	output logic            rxTake
);
	// shifter state is whatever the bench says
	assign tsrEmpty = shiftIdle;

	// burst fill and drain, one byte a cycle, capped at the depth
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			txCount <= 7'h00;
			rxCount <= 7'h00;
			rxArrive <= 1'b0;
			rxTake <= 1'b0;
		end
		else
		begin
			rxArrive <= rxCount < rxGoal && rxCount < 7'(FIFO_DEPTH);
			rxTake <= rxCount > rxGoal;
			if (rxCount < rxGoal && rxCount < 7'(FIFO_DEPTH))
				rxCount <= rxCount + 7'h01;
			else if (rxCount > rxGoal)
				rxCount <= rxCount - 7'h01;
			if (txCount < txGoal && txCount < 7'(FIFO_DEPTH))
				txCount <= txCount + 7'h01;
			else if (txCount > txGoal)
				txCount <= txCount - 7'h01;
		end
	end
endmodule

/* urib_pkg.sv */
// state types of the ready, interrupt and rate logic
// assumes nothing beyond a SystemVerilog compiler
package urib_pkg;

	// rate divider state
	typedef struct packed {
		logic [1:0]  pre;
		logic [15:0] div;
		logic [3:0]  sub;
		logic        sampleTick;
		logic        bitTick;
	} urib_div_t;

	// receive time-out state
	typedef struct packed {
		logic [7:0] bits;
		logic       timeout;
	} urib_to_t;

	// core registers and output flops
	typedef struct packed {
		logic [7:0] divLow;
		logic [7:0] divHigh;
		logic [7:0] fifoCtl;
		logic [7:0] lineCtl;
		logic [7:0] modemCtl;
		logic [7:0] enhMode;
		logic [7:0] featCtl;
		logic [7:0] txTrig;
		logic [7:0] rxTrig;
		logic       prescaleOwned;
		logic [2:0] pinSync;
		logic       prescalePin;
		logic [7:0] rdData;
		logic       rxReadyN;
		logic       txReadyN;
		logic       irqOut;
	} urib_core_t;

endpackage

/* urib_rate_divider.sv */
// prescaler and programmable divisor giving sampling and bit ticks
// assumes divisor and mode settings come from registers on mclk
`timescale 1ns/10ps
`include "urib_defines.svh"
module urib_rate_divider
	import urib_pkg::*;
(
	// clock and reset
	input wire logic  mclk,
	input wire logic  reset_n,
	input wire logic  ce,
	// settings in, ticks out
	urib_tick_if.gen  ticks
);
	urib_div_t s;
	urib_div_t next_s;
	logic      preHit;
	logic [3:0] lastSub;

	// ticks are enables on mclk, so no second clock domain exists
	always_comb
	begin
		next_s = s;
		next_s.sampleTick = 1'b0;
		next_s.bitTick = 1'b0;
		preHit = ticks.prescale4 ? (s.pre == `URIB_PRESCALE_LAST) : 1'b1;
		lastSub = ticks.mode16 ? `URIB_LAST_SAMPLE16 : `URIB_LAST_SAMPLE8;
		next_s.pre = (preHit || !ticks.prescale4) ? 2'h0 : s.pre + 2'h1;
		// a zero divisor stops the ticks; >= absorbs a divisor lowered mid-count
		if (preHit && ticks.divisor != 16'h0000)
		begin
			if (s.div >= ticks.divisor - 16'h0001)
			begin
				next_s.div = 16'h0000;
				next_s.sampleTick = 1'b1;
				if (s.sub >= lastSub)
				begin
					next_s.sub = 4'h0;
					next_s.bitTick = 1'b1;
				end
				else
					next_s.sub = s.sub + 4'h1;
			end
			else
				next_s.div = s.div + 16'h0001;
		end
	end

	// state register
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign ticks.sampleTick = s.sampleTick;
	assign ticks.bitTick = s.bitTick;
endmodule

/* urib_rx_timeout.sv */
// receive time-out: four words plus twelve bit times of silence
// assumes rxArrive and rxTake are one-cycle pulses on mclk
`timescale 1ns/10ps
`include "urib_defines.svh"
module urib_rx_timeout
	import urib_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        ce,
	// bit ticks
	urib_tick_if.sink       ticks,
	// receive side status
	input wire logic [1:0]  wordLen,
	input wire logic        rxHasData,
	input wire logic        rxArrive,
	input wire logic        rxTake,
	// event level
	output logic            timeout
);
	urib_to_t s;
	urib_to_t next_s;

	// bit times to wait for a given word-length field
	function automatic logic [7:0] waitBits(input logic [1:0] wl);
		waitBits = `URIB_TO_CHARS * (`URIB_WORD_BASE + {6'h00, wl})
		         + `URIB_TO_EXTRA_BITS;
	endfunction

	// fresh data or a host read restarts the silence count
	always_comb
	begin
		next_s = s;
		if (!rxHasData || rxArrive || rxTake)
		begin
			next_s.bits = 8'h00;
			next_s.timeout = 1'b0;
		end
		else if (ticks.bitTick && !s.timeout)
		begin
			next_s.bits = s.bits + 8'h01;
			if (s.bits >= waitBits(wordLen) - 8'h01)
				next_s.timeout = 1'b1;
		end
	end

	// state register
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign timeout = s.timeout;
endmodule

/* urib_tick_if.sv */
// carrier of rate settings and sampling ticks between the core's parts
// assumes all users run on the same mclk
`timescale 1ns/10ps
interface urib_tick_if;
	logic [15:0] divisor;
	logic        prescale4;
	logic        mode16;
	logic        sampleTick;
	logic        bitTick;
	modport gen  (input divisor, prescale4, mode16,
	              output sampleTick, bitTick);
	modport sink (input divisor, prescale4, mode16, sampleTick, bitTick);
endinterface
